// [design/timer2_pkg.sv]
// Constants shared by the timer two blocks
package timer2_pkg;
  // ==========================================================
  // Widths and full counts
  localparam int CNT_W = 16;
  localparam logic [15:0] FULL_NARROW = 16'h00FF;
  localparam logic [15:0] FULL_WIDE = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // ==========================================================
  // Count clock selection, upper nibble of the prescaler setting
  localparam int DIV_W = 11;
  localparam logic [3:0] PRESC_MAX_DIV = 4'h8;
  localparam logic [3:0] PRESC_EXTERNAL = 4'hF;
  localparam logic [11:0] DIV_BASE = 12'h008;
  localparam logic [11:0] DIV_ONE = 12'h001;
  localparam logic [DIV_W-1:0] DIV_RESET = 11'h000;
  // ==========================================================
  // Edge modes of the external pins
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // ==========================================================
  // Event pin timing, in system clocks
  localparam int EVENT_MIN_PHASE_CLK = 4;
  localparam int EVENT_MAX_RATE_DIV = 8;
  // ==========================================================
  // Counter sequencing states
  typedef enum logic [2:0] {
    ST_STOP,
    ST_ARMED,
    ST_RUN,
    ST_CAPCLR,
    ST_HOLD
  } cnt_state_t;
endpackage : timer2_pkg

// [design/edge_if.sv]
// Interface between an edge detector and its user
`timescale 1ns/1ns
interface edge_if;
  logic pin;
  logic [1:0] mode;
  logic edge_pulse;
  modport detector (input pin, input mode, output edge_pulse);
  modport user (output pin, output mode, input edge_pulse);
endinterface : edge_if

// [design/edge_detect.sv]
// Valid edge detector for one external input pin
`timescale 1ns/1ns
module edge_detect
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edge pulse
  edge_if.detector e
);
  logic pin_q;
  logic prev_q;
  logic edge_q;
  logic rise;
  logic fall;

  // Pin history, pin taken as synchronous
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      pin_q <= e.pin;
      prev_q <= pin_q;
    end
  end

  assign rise = pin_q & ~prev_q;
  assign fall = ~pin_q & prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      edge_q <= 1'b0;
    else
    begin
      case (e.mode)
        EDGE_FALL: edge_q <= fall;
        EDGE_RISE: edge_q <= rise;
        EDGE_BOTH: edge_q <= rise | fall;
        default: edge_q <= 1'b0;
      endcase
    end
  end

  assign e.edge_pulse = edge_q;
endmodule : edge_detect

// [design/count_clock_gen.sv]
// Count clock generator: prescaler or external event edges
`timescale 1ns/1ns
module count_clock_gen
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Selection and external edge
  input wire logic [3:0] sel,
  input wire logic ext_edge,
  // One-cycle count clock
  output logic tick
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  // Free running divider of the system clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_q <= DIV_RESET;
    else
      div_q <= div_q + 11'h001;
  end

  // Divide by eight up to 2048, one bit of mask per step
  assign mask = DIV_W'((DIV_BASE << sel) - DIV_ONE);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else if (sel == PRESC_EXTERNAL)
      tick <= ext_edge;
    else if (sel <= PRESC_MAX_DIV)
      tick <= ((div_q & mask) == mask);
    else
      tick <= 1'b0;
  end
endmodule : count_clock_gen

// [design/timer2_top.sv]
// Timer two: counter, clear control, one-shot, compare and capture
// What this block does
// - Compare B clear zeroes count on next tick
// - Enable low zeroes count immediately, stops
// - Re-enable before tick: that tick starts
// - Late re-enable: next tick starts from zero
// - Enable loads zero, increments after first tick
// - Enable rewritten one changes nothing
// - External select counts event pin edges
// - Event edges accepted up to fclk/8
// - Event pin also raises interrupt request
// - Oneshot select chooses one-shot mode
// - One-shot full count sets overflow, holds
// - Overflow clear restarts one-shot from zero
// - One-shot compares still raise match interrupts
// - Match sends pulse and interrupt request
// - Clear-on-match forms interval timer
// - Pin edges capture count into registers
// - Captured value held until next capture
// - Capture edge follows edge mode setting
// - Clear-on-capture clears after capture
// - Capture clear preceded by one increment
// - Width select picks 8 or 16 bits
// - Normal mode wraps, sets overflow, continues
`timescale 1ns/1ns
module timer2_top
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Control bits from software
  input wire logic COUNT_ENABLE_BIT,
  input wire logic ONESHOT_SELECT,
  input wire logic WIDTH_SELECT,
  input wire logic OVERFLOW_CLEAR,
  input wire logic [3:0] PRESCALER_SELECT,
  input wire logic CLEAR_ON_B_ENABLE,
  input wire logic CLEAR_ON_CAPTURE_ENABLE,
  input wire logic B_CAPTURE_MODE,
  input wire logic [1:0] EDGE_MODE_PIN_ONE,
  input wire logic [1:0] EDGE_MODE_PIN_TWO,
  // Compare values
  input wire logic [15:0] COMPARE_A,
  input wire logic [15:0] COMPARE_B,
  // External pins
  input wire logic CAPTURE_PIN_ONE,
  input wire logic EVENT_CAPTURE_PIN_TWO,
  // Count and flags
  output logic [15:0] TIMER_COUNT,
  output logic OVERFLOW_FLAG,
  output logic OVERFLOW_PULSE,
  // Capture registers
  output logic [15:0] CAPTURE_C,
  output logic [15:0] CAPTURE_B,
  // Match pulses and interrupt requests
  output logic MATCH_PULSE_A,
  output logic MATCH_PULSE_B,
  output logic MATCH_IRQ_A,
  output logic MATCH_IRQ_B,
  output logic PIN_ONE_IRQ,
  output logic PIN_TWO_IRQ
);
  // ==========================================================
  // Declarations
  cnt_state_t state_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] full;
  logic [15:0] inc;
  logic tick;
  logic tick_seen_q;
  logic clr_pend_q;
  logic cap_clr_pend_q;
  logic ovf_q;
  logic ovf_evt;
  logic ovf_pulse_q;
  logic running;
  logic hit_a;
  logic hit_b;
  logic match_a_q;
  logic match_b_q;
  logic irq_a_q;
  logic irq_b_q;
  logic cap_one;
  logic cap_two;
  logic [15:0] cap_c_q;
  logic [15:0] cap_b_q;
  logic pin1_irq_q;
  logic pin2_irq_q;
  logic restart_oneshot;

  // ==========================================================
  // Edge detection on both external pins
  edge_if pin_one ();
  edge_if pin_two ();

  assign pin_one.pin = CAPTURE_PIN_ONE;
  assign pin_one.mode = EDGE_MODE_PIN_ONE;
  assign pin_two.pin = EVENT_CAPTURE_PIN_TWO;
  assign pin_two.mode = EDGE_MODE_PIN_TWO;

  edge_detect u_edge_one (
    .clk(CLK),
    .rst_n(RST_N),
    .e(pin_one)
  );

  // Two-clock path resolves edges at fclk/8
  edge_detect u_edge_two (
    .clk(CLK),
    .rst_n(RST_N),
    .e(pin_two)
  );

  // ==========================================================
  // Count clock selection
  // Event counting by select only
  count_clock_gen u_clkgen (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(PRESCALER_SELECT),
    .ext_edge(pin_two.edge_pulse),
    .tick(tick)
  );

  // ==========================================================
  // Width and increment
  // Width select sets full count
  assign full = WIDTH_SELECT ? FULL_WIDE : FULL_NARROW;
  assign inc = (count_q + 16'h0001) & full;
  assign running = COUNT_ENABLE_BIT && (state_q != ST_STOP);

  // Captures and matches only while the counter is enabled
  assign cap_one = running && pin_one.edge_pulse;
  assign cap_two = running && B_CAPTURE_MODE && pin_two.edge_pulse;

  // Software clear of the overflow reruns a held one-shot
  assign restart_oneshot = (state_q == ST_HOLD) && OVERFLOW_CLEAR;

  // ==========================================================
  // Next count and overflow event
  always_comb
  begin
    count_d = count_q;
    ovf_evt = 1'b0;
    case (state_q)
      ST_RUN:
      begin
        if (tick)
        begin
          if (cap_clr_pend_q)
            count_d = inc;
          else if (clr_pend_q)
            count_d = COUNT_RESET;
          else if (ONESHOT_SELECT && (inc == full))
          begin
            count_d = full;
            ovf_evt = 1'b1;
          end
          else if (!ONESHOT_SELECT && ((count_q & full) == full))
          begin
            count_d = COUNT_RESET;
            ovf_evt = 1'b1;
          end
          else
            count_d = inc;
        end
      end
      // The count one above the capture has been seen once, now drop to zero
      ST_CAPCLR: count_d = COUNT_RESET;
      ST_ARMED: count_d = COUNT_RESET;
      ST_HOLD: count_d = restart_oneshot ? COUNT_RESET : count_q;
      default: count_d = COUNT_RESET;
    endcase
  end

  // ==========================================================
  // Counter register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      count_q <= COUNT_RESET;
    else if (!COUNT_ENABLE_BIT)
      count_q <= COUNT_RESET;
    else
      count_q <= count_d;
  end

  // ==========================================================
  // Sequencing states
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_q <= ST_STOP;
    else if (!COUNT_ENABLE_BIT)
      state_q <= ST_STOP;
    else
    begin
      case (state_q)
        // Late set waits for the following tick
        ST_STOP: state_q <= ST_ARMED;
        ST_ARMED:
          if (tick)
            state_q <= ST_RUN;
        ST_RUN:
          if (tick && cap_clr_pend_q)
            state_q <= ST_CAPCLR;
          else if (tick && ONESHOT_SELECT && !clr_pend_q && (inc == full))
            state_q <= ST_HOLD;
        ST_CAPCLR: state_q <= ST_RUN;
        ST_HOLD:
          if (restart_oneshot || !ONESHOT_SELECT)
            state_q <= ST_RUN;
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // ==========================================================
  // Count update marker, compare only on fresh counts
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      tick_seen_q <= 1'b0;
    else
      tick_seen_q <= COUNT_ENABLE_BIT && tick &&
                     ((state_q == ST_RUN) || (state_q == ST_ARMED));
  end

  assign hit_a = running && tick_seen_q && (count_q == (COMPARE_A & full));
  assign hit_b = running && tick_seen_q && !B_CAPTURE_MODE &&
                 (count_q == (COMPARE_B & full));

  // ==========================================================
  // Match pulses and interrupt requests
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end
    else
    begin
      match_a_q <= hit_a;
      match_b_q <= hit_b;
      irq_a_q <= hit_a;
      irq_b_q <= hit_b;
    end
  end

  // ==========================================================
  // Pending clears, consumed by the next tick
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      clr_pend_q <= 1'b0;
    else if (!COUNT_ENABLE_BIT)
      clr_pend_q <= 1'b0;
    else if (hit_b && CLEAR_ON_B_ENABLE)
      clr_pend_q <= 1'b1;
    else if (tick && state_q == ST_RUN)
      clr_pend_q <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      cap_clr_pend_q <= 1'b0;
    else if (!COUNT_ENABLE_BIT)
      cap_clr_pend_q <= 1'b0;
    else if ((cap_one || cap_two) && CLEAR_ON_CAPTURE_ENABLE)
      cap_clr_pend_q <= 1'b1;
    else if (tick && state_q == ST_RUN)
      cap_clr_pend_q <= 1'b0;
  end

  // ==========================================================
  // Capture registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      cap_c_q <= COUNT_RESET;
    else if (cap_one)
      cap_c_q <= count_q;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      cap_b_q <= COUNT_RESET;
    // Pin two fills B in capture mode
    else if (cap_two)
      cap_b_q <= count_q;
  end

  // ==========================================================
  // Overflow flag, set wins over software clear
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ovf_q <= 1'b0;
    else if (ovf_evt && COUNT_ENABLE_BIT)
      ovf_q <= 1'b1;
    else if (OVERFLOW_CLEAR)
      ovf_q <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ovf_pulse_q <= 1'b0;
    else
      ovf_pulse_q <= ovf_evt && COUNT_ENABLE_BIT;
  end

  // ==========================================================
  // External interrupt requests from both pins
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pin1_irq_q <= 1'b0;
      pin2_irq_q <= 1'b0;
    end
    else
    begin
      pin1_irq_q <= pin_one.edge_pulse;
      pin2_irq_q <= pin_two.edge_pulse;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign TIMER_COUNT = count_q;
  assign OVERFLOW_FLAG = ovf_q;
  assign OVERFLOW_PULSE = ovf_pulse_q;
  assign CAPTURE_C = cap_c_q;
  assign CAPTURE_B = cap_b_q;
  assign MATCH_PULSE_A = match_a_q;
  assign MATCH_PULSE_B = match_b_q;
  assign MATCH_IRQ_A = irq_a_q;
  assign MATCH_IRQ_B = irq_b_q;
  assign PIN_ONE_IRQ = pin1_irq_q;
  assign PIN_TWO_IRQ = pin2_irq_q;
endmodule : timer2_top

// [tb/timer2_checker.sv]
// Port checker for timer two
`timescale 1ns/1ns
module timer2_checker
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Control bits
  input wire logic COUNT_ENABLE_BIT,
  input wire logic ONESHOT_SELECT,
  input wire logic WIDTH_SELECT,
  input wire logic OVERFLOW_CLEAR,
  // Watched outputs
  input wire logic [15:0] TIMER_COUNT,
  input wire logic OVERFLOW_FLAG,
  input wire logic OVERFLOW_PULSE,
  input wire logic [15:0] CAPTURE_C,
  input wire logic MATCH_PULSE_A,
  input wire logic MATCH_IRQ_A,
  input wire logic MATCH_PULSE_B,
  input wire logic MATCH_IRQ_B,
  input wire logic PIN_ONE_IRQ
);
  logic held;
  // One-shot parked at full count of the chosen width
  assign held = ONESHOT_SELECT && COUNT_ENABLE_BIT && OVERFLOW_FLAG
    && TIMER_COUNT == (WIDTH_SELECT ? FULL_WIDE : FULL_NARROW);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Counter sequencing
  property p_stop; !COUNT_ENABLE_BIT |=> TIMER_COUNT == 16'h0000; endproperty
  a_stop: assert property (p_stop) else $error("count kept after stop");
  property p_step; $changed(TIMER_COUNT) |-> TIMER_COUNT == 16'h0000
    || TIMER_COUNT == $past(TIMER_COUNT) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_hold; held && !OVERFLOW_CLEAR |=> $stable(TIMER_COUNT); endproperty
  a_hold: assert property (p_hold) else $error("one-shot left full count");
  property p_rerun; held && OVERFLOW_CLEAR |=> TIMER_COUNT == 16'h0000; endproperty
  a_rerun: assert property (p_rerun) else $error("one-shot not rerun");
  property p_narrow; !WIDTH_SELECT |-> TIMER_COUNT[15:8] == 8'h00; endproperty
  a_narrow: assert property (p_narrow) else $error("upper byte in narrow mode");
  // ==========================================================
  // Flags, matches and captures
  property p_sticky; OVERFLOW_FLAG && !OVERFLOW_CLEAR |=> OVERFLOW_FLAG; endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
  property p_wrap; OVERFLOW_PULSE && !ONESHOT_SELECT |-> OVERFLOW_FLAG
    && TIMER_COUNT == 16'h0000 ##1 !OVERFLOW_PULSE; endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_match; MATCH_PULSE_A |-> MATCH_IRQ_A ##1 !MATCH_PULSE_A; endproperty
  a_match: assert property (p_match) else $error("match pulse without request");
  property p_match_b; MATCH_PULSE_B |-> MATCH_IRQ_B ##1 !MATCH_PULSE_B; endproperty
  a_match_b: assert property (p_match_b) else $error("match b pulse without request");
  property p_cap; !PIN_ONE_IRQ |-> $stable(CAPTURE_C); endproperty
  a_cap: assert property (p_cap) else $error("capture moved without edge");
endmodule : timer2_checker

bind timer2_top timer2_checker i_timer2_checker (.*);

// [tb/pin_src.sv]
// Edge source model standing on one external pin
`timescale 1ns/1ns
module pin_src
(
  // Clock
  input wire logic clk,
  // Request: toggles and phase length
  input wire logic go,
  input wire logic [3:0] half,
  input wire logic [7:0] edges,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [7:0] left_q;
  logic [3:0] cnt_q;
  // Idle pin low
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Phase is clamped, a shorter pulse might be lost
  // phases at least four clocks
  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      left_q <= edges;
      cnt_q <= 4'h1;
      busy <= edges != 8'h00;
    end
    else if (busy && cnt_q >= (half < 4'h4 ? 4'h4 : half))
    begin
      pin <= !pin;
      cnt_q <= 4'h1;
      left_q <= left_q - 8'h01;
      busy <= left_q != 8'h01;
    end
    else if (busy)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : pin_src

// [tb/timer2_top_tb.sv]
// Self-checking bench for timer two
`timescale 1ns/1ns
module timer2_top_tb
  import timer2_pkg::*;
;
  logic clk, rst_n, en, os, ws, ovc, clrb, clrc, bcap, go1, go2;
  logic [3:0] presc, half;
  logic [1:0] em1, em2;
  logic [7:0] edges;
  logic [15:0] cmpa, cmpb, cnt, capc, capb, sv;
  logic ovf, ovp, mpa, mpb, mia, mib, irq1, irq2, pin1, pin2, busy1, busy2;
  int err_count = 0, cmp_count = 0, i1 = 0, i2 = 0, ma = 0, mb = 0, op = 0, k, n, mx;
  int pl = 0;
  logic [1:0] evm [2] = '{EDGE_BOTH, EDGE_RISE};
  int dly [2] = '{1, 20};
  timer2_top i_timer2_top (
    .CLK(clk), .RST_N(rst_n), .COUNT_ENABLE_BIT(en), .ONESHOT_SELECT(os),
    .WIDTH_SELECT(ws), .OVERFLOW_CLEAR(ovc), .PRESCALER_SELECT(presc),
    .CLEAR_ON_B_ENABLE(clrb), .CLEAR_ON_CAPTURE_ENABLE(clrc), .B_CAPTURE_MODE(bcap),
    .EDGE_MODE_PIN_ONE(em1), .EDGE_MODE_PIN_TWO(em2), .COMPARE_A(cmpa),
    .COMPARE_B(cmpb), .CAPTURE_PIN_ONE(pin1), .EVENT_CAPTURE_PIN_TWO(pin2),
    .TIMER_COUNT(cnt), .OVERFLOW_FLAG(ovf), .OVERFLOW_PULSE(ovp), .CAPTURE_C(capc),
    .CAPTURE_B(capb), .MATCH_PULSE_A(mpa), .MATCH_PULSE_B(mpb), .MATCH_IRQ_A(mia),
    .MATCH_IRQ_B(mib), .PIN_ONE_IRQ(irq1), .PIN_TWO_IRQ(irq2));
  pin_src i_pin_one (.clk(clk), .go(go1), .half(half), .edges(edges), .pin(pin1),
    .busy(busy1));
  pin_src i_pin_two (.clk(clk), .go(go2), .half(half), .edges(edges), .pin(pin2),
    .busy(busy2));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulse tallies, zeroed by each scenario that checks them
  always @(posedge clk)
  begin
    i1 <= i1 + (irq1 === 1'b1);
    i2 <= i2 + (irq2 === 1'b1);
    ma <= ma + (mia === 1'b1);
    mb <= mb + (mib === 1'b1);
    op <= op + (ovp === 1'b1);
    // Count one above the last capture, seen only on the step before a clear
    pl <= pl | (cnt === capc + 16'h0001);
  end
  // Valid edges among t toggles from low, t even
  function automatic int edges_of(input logic [1:0] m, input int t);
    case (m)
      EDGE_FALL, EDGE_RISE: return t / 2;
      EDGE_BOTH: return t;
      default: return 0;
    endcase
  endfunction : edges_of
  task automatic tally_and_finish;
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for a count value
  task automatic wait_cnt(input logic [15:0] v, output int w);
    w = 0;
    while (cnt !== v && w < 5000)
    begin
      @(negedge clk);
      w++;
    end
    chk("wait count", v, cnt);
    if (w >= 5000)
      tally_and_finish;
  endtask : wait_cnt
  // Ask a pin source for toggles and wait until it is done
  task automatic send(input logic w, input logic [7:0] t);
    int c;
    edges = t;
    go1 = !w;
    go2 = w;
    @(negedge clk);
    {go1, go2} = 2'b00;
    c = 0;
    while ((busy1 || busy2) && c < 900)
    begin
      @(negedge clk);
      c++;
    end
    repeat (5) @(negedge clk);
    chk("pin source done", 16'h0000, 16'(c >= 900));
    if (c >= 900)
      tally_and_finish;
  endtask : send
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, en, os, ws, ovc, clrb, clrc, bcap, go1, go2} = 10'h000;
    {presc, half, edges, em1, em2} = {4'h0, 4'h4, 8'h00, EDGE_RISE, EDGE_BOTH};
    {cmpa, cmpb} = 32'h0000_0000;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    void'($urandom(32'h83C4));
    chk("reset count", COUNT_RESET, cnt);
    // Normal narrow run through a wrap
    cmpa = 16'($urandom_range(240, 16));
    en = 1'b1;
    wait_cnt(16'h0001, k);
    en = 1'b1;
    repeat (8) @(negedge clk);
    chk("count step", 16'h0002, cnt);
    {ma, op} = 64'h0;
    wait_cnt(COUNT_RESET, k);
    repeat (8) @(negedge clk);
    chk("count after wrap", 16'h0001, cnt);
    chk("overflow flag", 16'h0001, ovf);
    chk("overflow pulses", 16'h0001, 16'(op));
    chk("match a pulses", 16'h0001, 16'(ma));
    ovc = 1'b1;
    @(negedge clk);
    ovc = 1'b0;
    chk("flag cleared", 16'h0000, ovf);
    // Stop, then restart early and late
    foreach (dly[i])
    begin
      wait_cnt(16'h0003, k);
      en = 1'b0;
      @(negedge clk);
      chk("stop clears", 16'h0000, cnt);
      repeat (dly[i]) @(negedge clk);
      en = 1'b1;
      wait_cnt(16'h0001, k);
      chk("restart delay", 16'h0001, 16'(k >= 8 && k <= 17));
    end
    // One-shot with both compares
    en = 1'b0;
    os = 1'b1;
    cmpa = 16'($urandom_range(200, 2));
    cmpb = 16'($urandom_range(250, 201));
    {ma, mb} = 64'h0;
    @(negedge clk);
    en = 1'b1;
    wait_cnt(FULL_NARROW, k);
    repeat (30) @(negedge clk);
    chk("one-shot hold", FULL_NARROW, cnt);
    chk("one-shot flag", 16'h0001, ovf);
    chk("one-shot match a", 16'h0001, 16'(ma));
    chk("one-shot match b", 16'h0001, 16'(mb));
    ovc = 1'b1;
    @(negedge clk);
    ovc = 1'b0;
    chk("rerun zero", 16'h0000, cnt);
    wait_cnt(16'h0002, k);
    chk("rerun counts", 16'h0001, 16'(k <= 24));
    en = 1'b0;
    os = 1'b0;
    // Interval timer on compare b
    cmpb = 16'($urandom_range(30, 3));
    clrb = 1'b1;
    @(negedge clk);
    en = 1'b1;
    wait_cnt(cmpb, k);
    // Eight periods of the longest interval, eight clocks per tick
    {mx, k, mb} = 96'h0;
    repeat (8 * 8 * 32 + 40)
    begin
      @(negedge clk);
      if (cnt === cmpb)
        k++;
      if (cnt > mx)
        mx = cnt;
    end
    chk("interval top", cmpb, 16'(mx));
    chk("matched value held", 16'h0001, 16'(k >= 8 * 8));
    chk("interval matches", 16'h0001, 16'(mb >= 8));
    {en, clrb} = 2'b00;
    // Wide captures on both pins
    {ws, bcap} = 2'b11;
    @(negedge clk);
    en = 1'b1;
    wait_cnt(16'h0101, k);
    chk("no wrap at narrow full", 16'h0000, ovf);
    for (int i = 0; i < 4; i++)
    begin
      em1 = 2'(i);
      i1 = 0;
      sv = capc;
      send(1'b0, 8'h02);
      chk("pin one edges", 16'(edges_of(em1, 2)), 16'(i1));
      if (em1 == EDGE_NONE)
        chk("capture kept", sv, capc);
    end
    em1 = EDGE_RISE;
    send(1'b0, 8'h01);
    chk("capture c", 16'h0001, 16'(cnt - capc <= 16'h0001));
    sv = capc;
    send(1'b0, 8'h01);
    chk("capture c kept", sv, capc);
    send(1'b1, 8'h01);
    chk("capture b", 16'h0001, 16'(cnt - capb <= 16'h0001));
    clrc = 1'b1;
    pl = 0;
    send(1'b0, 8'h01);
    // Let the tick that adds one and the zeroing edge pass
    repeat (12) @(negedge clk);
    chk("clear on capture", 16'h0001, 16'(cnt <= 16'h0001));
    chk("step before clear", 16'h0001, 16'(pl));
    {en, clrc, ws, bcap} = 4'h0;
    // Event counting on pin two at the top rate
    presc = PRESC_EXTERNAL;
    foreach (evm[i])
    begin
      em2 = evm[i];
      @(negedge clk);
      en = 1'b1;
      n = 2 * $urandom_range(20, 3);
      i2 = 0;
      repeat (3) @(negedge clk);
      send(1'b1, 8'(n));
      chk("event count", 16'(edges_of(em2, n) - 1), cnt);
      chk("event requests", 16'(edges_of(em2, n)), 16'(i2));
      en = 1'b0;
    end
    tally_and_finish;
  end
endmodule : timer2_top_tb
